// ==== rtl/dmt_timers.sv ====
// two multifunction 8-bit timers with nibble register port
module dmt_timers
  import dmt_pkg::*;
#(
  parameter int TAPS = TAP_N
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [NIB_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [NIB_W-1:0] rdata,
  input wire logic [TAPS-1:0] prescale_tick,
  input wire logic event_trigger_pin,
  output logic first_timer_output,
  output logic timer_c_pin_sel,
  output logic second_timer_output,
  output logic timer_d_pin_sel,
  output logic first_counter_irq_flag,
  output logic second_counter_irq_flag,
  output logic mcu_reset_req
);
  if (TAPS < 1 || TAPS > 7) begin : g_chk
    $error("dmt_timers needs one to seven prescaler taps");
  end

  // next output level for the four timer output modes
  function automatic logic out_next(input logic [2:0] om, input logic cur, input logic ovf,
                                    input logic [7:0] cnt, input logic [7:0] ld);
    logic r;
    r = cur;
    if (om[2]) begin
      r = (cnt < ld);
    end else begin
      case (om[1:0])
        OM_TOGGLE: r = ovf ? ~cur : cur;
        OM_LOW: r = ovf ? 1'b0 : cur;
        OM_HIGH: r = ovf ? 1'b1 : cur;
        default: r = cur;
      endcase
    end
    return r;
  endfunction

  // clock pick: prescaler tap or event edge
  function automatic logic tick_pick(input logic [2:0] sel, input logic [TAPS-1:0] taps,
                                     input logic ev);
    logic r;
    r = 1'b0;
    if (sel == SEL_EVENT) begin
      r = ev;
    end else if (32'(sel) < TAPS) begin
      r = taps[sel];
    end
    return r;
  endfunction

  // write decode
  logic wr_c_mode, wr_d_mode, wr_c_low, wr_c_high, wr_d_low, wr_d_high;
  assign wr_c_mode = wr_stb && (addr == A_C_MODE);
  assign wr_d_mode = wr_stb && (addr == A_D_MODE);
  assign wr_c_low = wr_stb && (addr == A_C_LOW);
  assign wr_c_high = wr_stb && (addr == A_C_HIGH);
  assign wr_d_low = wr_stb && (addr == A_D_LOW);
  assign wr_d_high = wr_stb && (addr == A_D_HIGH);

  // count mode registers, c at index 0 and d at index 1
  logic [3:0] mode_pend_r [2];
  logic [3:0] mode_eff_r [2];
  logic [1:0] mode_dly_r [2];
  logic mode_wr [2];
  assign mode_wr[0] = wr_c_mode;
  assign mode_wr[1] = wr_d_mode;

  // a write is held back so it acts from the second cycle on
  for (genvar i = 0; i < 2; i++) begin : g_mode
    always_ff @(posedge clk) begin
      if (srst) begin
        mode_pend_r[i] <= NIB_RST;
        mode_eff_r[i] <= NIB_RST;
        mode_dly_r[i] <= 2'h0;
      end else if (mode_wr[i]) begin
        mode_pend_r[i] <= wdata;
        mode_dly_r[i] <= MODE_DLY - 2'h1; // commit one edge on, so counters use it from cycle 2
      end else if (mode_dly_r[i] != 2'h0) begin
        mode_dly_r[i] <= mode_dly_r[i] - 2'h1;
        if (mode_dly_r[i] == 2'h1) begin
          mode_eff_r[i] <= mode_pend_r[i];
        end
      end
    end
  end

  // load registers; low nibble waits for the high write
  logic [3:0] c_load_lo_r, c_load_hi_r, d_load_lo_r, d_load_hi_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      c_load_lo_r <= NIB_RST;
      c_load_hi_r <= NIB_RST;
      d_load_lo_r <= NIB_RST;
      d_load_hi_r <= NIB_RST;
    end else begin
      if (wr_c_low) c_load_lo_r <= wdata;
      if (wr_c_high) c_load_hi_r <= wdata;
      if (wr_d_low) d_load_lo_r <= wdata;
      if (wr_d_high) d_load_hi_r <= wdata;
    end
  end

  // the high write loads the nibble on the bus; the register holds it for later reloads and the PWM compare
  logic [7:0] c_load_val, d_load_val;
  assign c_load_val = {wr_c_high ? wdata : c_load_hi_r, c_load_lo_r};
  assign d_load_val = {wr_d_high ? wdata : d_load_hi_r, d_load_lo_r};

  // output mode, watchdog, pin function and edge select registers
  logic [2:0] c_out_mode_r;
  logic [3:0] d_out_mode_r;
  logic wdog_en_r;
  logic [3:0] pin_func_r, edge_sel_r;
  logic capt_sel_wr;
  assign capt_sel_wr = wr_stb && (addr == A_D_OUT) && wdata[B_CAPT] && !d_out_mode_r[B_CAPT];
  always_ff @(posedge clk) begin
    if (srst) begin
      c_out_mode_r <= 3'h0;
      d_out_mode_r <= NIB_RST;
      wdog_en_r <= 1'b0;
      pin_func_r <= NIB_RST;
      edge_sel_r <= NIB_RST;
    end else if (wr_stb) begin
      if (addr == A_C_OUT) c_out_mode_r <= wdata[2:0];
      if (addr == A_D_OUT) d_out_mode_r <= wdata;
      if (addr == A_WDOG) wdog_en_r <= wdata[B_WATCHDOG_ENABLE_FLAG];
      if (addr == A_PINF) pin_func_r <= wdata;
      if (addr == A_EDGE) edge_sel_r <= wdata;
    end
  end

  // event pin edge detection; pin is synchronous to clk
  logic ev_prev_r;
  logic ev_edge;
  always_ff @(posedge clk) begin
    if (srst) ev_prev_r <= 1'b0;
    else ev_prev_r <= event_trigger_pin;
  end
  always_comb begin
    ev_edge = 1'b0;
    if (pin_func_r[B_EVPIN]) begin
      case (edge_sel_r[1:0])
        ED_FALL: ev_edge = ev_prev_r && !event_trigger_pin;
        ED_RISE: ev_edge = !ev_prev_r && event_trigger_pin;
        ED_BOTH: ev_edge = ev_prev_r != event_trigger_pin;
        default: ev_edge = 1'b0;
      endcase
    end
  end

  // counters
  logic d_capt;
  logic capt_hit;
  logic tick_c, tick_d, ovf_c, ovf_d;
  logic [7:0] cnt_c, cnt_d;
  assign d_capt = d_out_mode_r[B_CAPT];
  assign capt_hit = d_capt && ev_edge;
  assign tick_c = tick_pick(mode_eff_r[0][2:0], prescale_tick, 1'b0);
  // in capture mode the event edge is a trigger, never a count clock
  assign tick_d = tick_pick(mode_eff_r[1][2:0], prescale_tick, ev_edge && !d_capt);

  dmt_counter #(.WIDTH(CNT_W)) u_cnt_c (
    .clk(clk),
    .srst(srst),
    .tick(tick_c),
    .reload_mode(mode_eff_r[0][B_RELOAD]),
    .load_val(c_load_val),
    .load_now(wr_c_high),
    .clear_now(1'b0),
    .count(cnt_c),
    .ovf(ovf_c)
  );

  dmt_counter #(.WIDTH(CNT_W)) u_cnt_d (
    .clk(clk),
    .srst(srst),
    .tick(tick_d),
    .reload_mode(mode_eff_r[1][B_RELOAD]),
    .load_val(d_load_val),
    .load_now(wr_d_high),
    .clear_now(capt_hit || capt_sel_wr),
    .count(cnt_d),
    .ovf(ovf_d)
  );

  // irq flags; a hardware set wins over a software clear
  logic irq_c_r, irq_d_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_c_r <= 1'b0;
    end else if (ovf_c) begin
      irq_c_r <= 1'b1;
    end else if (wr_stb && addr == A_IRQ_C && !wdata[B_IRQ_C]) begin
      irq_c_r <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_d_r <= 1'b0;
    end else if (ovf_d || capt_hit) begin
      irq_d_r <= 1'b1;
    end else if (wr_stb && addr == A_IRQ_D && !wdata[B_IRQ_D]) begin
      irq_d_r <= 1'b0;
    end
  end
  assign first_counter_irq_flag = irq_c_r;
  assign second_counter_irq_flag = irq_d_r;

  // watchdog request, one cycle per overflow
  always_ff @(posedge clk) begin
    if (srst) mcu_reset_req <= 1'b0;
    else mcu_reset_req <= wdog_en_r && ovf_c;
  end

  // capture value and flags
  logic [7:0] capt_val_r;
  logic csf_r, cef_r;
  logic capt_clr;
  assign capt_clr = wr_stb && (addr == A_CAPT);
  always_ff @(posedge clk) begin
    if (srst) capt_val_r <= CNT_RST;
    else if (capt_hit) capt_val_r <= cnt_d;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      csf_r <= 1'b0;
      cef_r <= 1'b0;
    end else begin
      if (capt_hit) csf_r <= 1'b1;
      else if (capt_clr && !wdata[B_CSF]) csf_r <= 1'b0;
      if (d_capt && csf_r && (capt_hit || ovf_d)) cef_r <= 1'b1;
      else if (capt_clr && !wdata[B_CEF]) cef_r <= 1'b0;
    end
  end

  // timer output pins; capture mode gives the second pin back to the port
  always_ff @(posedge clk) begin
    if (srst) begin
      first_timer_output <= 1'b0;
      timer_c_pin_sel <= 1'b0;
      second_timer_output <= 1'b0;
      timer_d_pin_sel <= 1'b0;
    end else begin
      timer_c_pin_sel <= c_out_mode_r != 3'h0;
      first_timer_output <= out_next(c_out_mode_r, first_timer_output, ovf_c, cnt_c,
                                     {c_load_hi_r, c_load_lo_r});
      timer_d_pin_sel <= (d_out_mode_r[2:0] != 3'h0) && !d_capt;
      second_timer_output <= d_capt ? 1'b0 : out_next(d_out_mode_r[2:0], second_timer_output, ovf_d,
                                                      cnt_d, {d_load_hi_r, d_load_lo_r});
    end
  end

  // count read latches, taken when the high nibble is read
  logic [3:0] c_lat_r, d_lat_r;
  logic rd_c_high, rd_d_high;
  assign rd_c_high = rd_stb && (addr == A_C_HIGH);
  assign rd_d_high = rd_stb && (addr == A_D_HIGH);
  always_ff @(posedge clk) begin
    if (srst) begin
      c_lat_r <= NIB_RST;
      d_lat_r <= NIB_RST;
    end else begin
      if (rd_c_high) c_lat_r <= cnt_c[3:0];
      if (rd_d_high) d_lat_r <= cnt_d[3:0];
    end
  end

  // read data stand one cycle after the strobe; write-only and unmapped read zero
  logic [3:0] rd_nxt;
  always_comb begin
    rd_nxt = 4'h0;
    case (addr)
      A_IRQ_C: rd_nxt[B_IRQ_C] = irq_c_r;
      A_IRQ_D: rd_nxt[B_IRQ_D] = irq_d_r;
      A_C_LOW: rd_nxt = c_lat_r;
      A_C_HIGH: rd_nxt = cnt_c[7:4];
      A_D_LOW: rd_nxt = d_capt ? capt_val_r[3:0] : d_lat_r;
      A_D_HIGH: rd_nxt = d_capt ? capt_val_r[7:4] : cnt_d[7:4];
      A_C_OUT: rd_nxt = {1'b0, c_out_mode_r};
      A_D_OUT: rd_nxt = d_out_mode_r;
      A_WDOG: rd_nxt[B_WATCHDOG_ENABLE_FLAG] = wdog_en_r;
      A_CAPT: rd_nxt = {2'b00, cef_r, csf_r};
      default: rd_nxt = 4'h0;
    endcase
  end
  always_ff @(posedge clk) begin
    if (srst) rdata <= 4'h0;
    else if (rd_stb) rdata <= rd_nxt;
    else rdata <= 4'h0;
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  ovf_reload_a: assert property (ovf_c && mode_eff_r[0][B_RELOAD] && !wr_c_high |=>
    cnt_c == $past({c_load_hi_r, c_load_lo_r})) else $error("first counter did not reload");
  ovf_free_a: assert property (ovf_c && !mode_eff_r[0][B_RELOAD] && !wr_c_high |=>
    cnt_c == 8'h00) else $error("first counter did not restart at zero");
  irq_c_set_a: assert property (ovf_c |=> irq_c_r) else $error("first irq flag missed");
  wdog_reset_a: assert property (wdog_en_r && ovf_c |=> mcu_reset_req)
    else $error("watchdog did not request reset");
  toggle_out_a: assert property (c_out_mode_r == 3'h1 && ovf_c |=>
    first_timer_output != $past(first_timer_output)) else $error("toggle output did not invert");
  mode_delay_a: assert property (wr_c_mode ##1 !wr_c_mode ##1 !wr_c_mode |->
    mode_eff_r[0] == $past(wdata, 2)) else $error("count mode not effective after delay");
  low_only_a: assert property (wr_c_low && !tick_c |=> $stable(cnt_c))
    else $error("low nibble write changed the count");
  high_load_a: assert property (wr_c_high |=> cnt_c == {c_load_hi_r, c_load_lo_r})
    else $error("high nibble write did not load");
  read_pair_a: assert property (rd_c_high ##1 rd_stb && addr == A_C_LOW |=>
    rdata == $past(cnt_c[3:0], 2)) else $error("low nibble read not coherent");
  capt_copy_a: assert property (capt_hit |=> capt_val_r == $past(cnt_d) && csf_r && irq_d_r
    && cnt_d == 8'h00) else $error("capture did not copy and clear");
  capt_err_a: assert property (d_capt && csf_r && capt_hit |=> cef_r)
    else $error("capture error flag missed");
  capt_pin_a: assert property (d_capt |=> !timer_d_pin_sel)
    else $error("capture mode left second pin to the timer");

  pwm_seen_c: cover property (c_out_mode_r[2] && ovf_c);
  wdog_seen_c: cover property (mcu_reset_req);
  capt_err_c: cover property (cef_r);
  event_cnt_c: cover property (tick_d && mode_eff_r[1][2:0] == SEL_EVENT);
endmodule

// ==== common/dmt_pkg.sv ====
// constants shared by the dual multifunction timer block
package dmt_pkg;
  localparam int ADDR_W = 6;
  localparam int NIB_W = 4;
  localparam int CNT_W = 8;
  localparam int TAP_N = 7;
  // register offsets
  localparam logic [5:0] A_IRQ_C = 6'h02;
  localparam logic [5:0] A_IRQ_D = 6'h03;
  localparam logic [5:0] A_C_MODE = 6'h0d;
  localparam logic [5:0] A_C_LOW = 6'h0e;
  localparam logic [5:0] A_C_HIGH = 6'h0f;
  localparam logic [5:0] A_D_MODE = 6'h10;
  localparam logic [5:0] A_D_LOW = 6'h11;
  localparam logic [5:0] A_D_HIGH = 6'h12;
  localparam logic [5:0] A_C_OUT = 6'h14;
  localparam logic [5:0] A_D_OUT = 6'h15;
  localparam logic [5:0] A_WDOG = 6'h20;
  localparam logic [5:0] A_CAPT = 6'h21;
  localparam logic [5:0] A_PINF = 6'h25;
  localparam logic [5:0] A_EDGE = 6'h27;
  // field positions
  localparam int B_IRQ_C = 2;
  localparam int B_IRQ_D = 0;
  localparam int B_WATCHDOG_ENABLE_FLAG = 1;
  localparam int B_CSF = 0;
  localparam int B_CEF = 1;
  localparam int B_EVPIN = 1;
  localparam int B_RELOAD = 3;
  localparam int B_CAPT = 3;
  // clock select code for the event pin
  localparam logic [2:0] SEL_EVENT = 3'h7;
  // output mode codes
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_LOW = 2'h2;
  localparam logic [1:0] OM_HIGH = 2'h3;
  // edge select codes
  localparam logic [1:0] ED_FALL = 2'h1;
  localparam logic [1:0] ED_RISE = 2'h2;
  localparam logic [1:0] ED_BOTH = 2'h3;
  // reset values and timing
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [1:0] MODE_DLY = 2'h2;
endpackage

// ==== rtl/dmt_counter.sv ====
// one 8-bit up-counter with load, clear, reload and overflow
module dmt_counter
  import dmt_pkg::*;
#(
  parameter int WIDTH = CNT_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic tick,
  input wire logic reload_mode,
  input wire logic [WIDTH-1:0] load_val,
  input wire logic load_now,
  input wire logic clear_now,
  output logic [WIDTH-1:0] count,
  output logic ovf
);
  logic [WIDTH-1:0] count_r;

  if (WIDTH < 2) begin : g_chk
    $error("dmt_counter width too small");
  end

  // overflow is a clock arriving at the all-ones count
  assign ovf = tick && (count_r == {WIDTH{1'b1}});
  assign count = count_r;

  // software load wins over capture clear, which wins over counting
  always_ff @(posedge clk) begin
    if (srst) begin
      count_r <= '0;
    end else if (load_now) begin
      count_r <= load_val;
    end else if (clear_now) begin
      count_r <= '0;
    end else if (ovf) begin
      count_r <= reload_mode ? load_val : '0;
    end else if (tick) begin
      count_r <= count_r + 1'b1;
    end
  end
endmodule

// ==== dv/dmt_evsrc.sv ====
// behavioural source of pulses on the event and capture pin
module dmt_evsrc (
  input wire logic clk,
  input wire logic srst,
  input wire logic fire,
  input wire logic [2:0] width,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] left_r;

  // one high pulse per fire; width of two or more keeps edges two cycles apart
  always_ff @(posedge clk) begin
    if (srst) begin
      pin <= 1'b0;
      left_r <= 3'h0;
    end else if (left_r != 3'h0) begin
      left_r <= left_r - 3'h1;
      if (left_r == 3'h1) begin
        pin <= 1'b0;
      end
    end else if (fire) begin
      pin <= 1'b1;
      left_r <= width;
    end
  end
endmodule

// ==== dv/dual_multifunction_timers_tb.sv ====
// self-checking bench for the dual multifunction timers
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; $display("Error %s expected %h seen %h", n, e, g); end end
module dual_multifunction_timers_tb
  import dmt_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] addr = 6'h00;
  logic [3:0] wdata = 4'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [6:0] prescale_tick = 7'h00;
  logic fire = 1'b0;
  logic [2:0] wid = 3'h2;
  logic evt;
  logic [3:0] rdata;
  logic out_c;
  logic sel_c;
  logic out_d;
  logic sel_d;
  logic irq_c;
  logic irq_d;
  logic wdog;
  int fails = 0;
  int cmp_count = 0;
  int seed = 32'h731d;
  int cyc = 0;
  int wd_seen = 0;
  int n;
  int tp = 0;
  logic rl;
  logic [3:0] nib;
  logic [7:0] v;
  logic [7:0] l;
  logic [3:0] om [4] = '{4'h1, 4'h1, 4'h3, 4'h2};
  logic ex [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  always #12.5 clk = ~clk;

  dmt_timers dut_u (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .prescale_tick(prescale_tick), .event_trigger_pin(evt), .first_timer_output(out_c),
    .timer_c_pin_sel(sel_c), .second_timer_output(out_d), .timer_d_pin_sel(sel_d),
    .first_counter_irq_flag(irq_c), .second_counter_irq_flag(irq_d), .mcu_reset_req(wdog));
  dmt_evsrc src_u (.clk(clk), .srst(srst), .fire(fire), .width(wid), .pin(evt));

  // count from the load value, wrapping to the load or to zero
  function automatic logic [7:0] exp_cnt(input logic [7:0] ld, input int k, input logic rel);
    logic [7:0] c;
    c = ld;
    repeat (k) c = (c == CNT_MAX) ? (rel ? ld : CNT_RST) : c + 8'h01;
    return c;
  endfunction

  // bus cycles: strobe set after one edge, taken at the next
  task automatic wr(input logic [5:0] a, input logic [3:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [3:0] d);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk_rd(input logic [5:0] a, input logic [3:0] e, input string nm);
    rd(a, nib);
    `CHK(nm, e, nib)
  endtask
  // high nibble first so the low nibble is the latched one
  // the two reads follow with no gap, strobe held high across them
  task automatic chk_cnt(input logic [5:0] hi, input logic [7:0] e, input string nm);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr <= hi;
    @(posedge clk);
    addr <= hi - 6'h01;
    #1 v[7:4] = rdata;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v[3:0] = rdata;
    `CHK(nm, e, v)
  endtask
  task automatic load(input logic [5:0] lo, input logic [7:0] x);
    wr(lo, x[3:0]);
    wr(lo + 6'h01, x[7:4]);
  endtask
  // the mode needs two cycles before a load may follow
  task automatic set_mode(input logic [5:0] a, input logic [3:0] m);
    wr(a, m);
    repeat (2) @(posedge clk);
  endtask
  // tap tp pulses with noise on the others; all taps go quiet so a later tap pick sees no stale level
  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge clk);
      prescale_tick <= 7'(($random(seed) & 32'h7f & ~(32'h1 << tp)) | (32'h1 << tp));
      @(posedge clk);
      prescale_tick <= 7'($random(seed) & 32'h7f & ~(32'h1 << tp));
    end
    @(posedge clk);
    prescale_tick <= 7'h00;
    @(posedge clk);
    #1;
  endtask
  task automatic pulse();
    @(posedge clk);
    fire <= 1'b1;
    wid <= 3'h2 + 3'($random(seed) & 32'h3);
    @(posedge clk);
    fire <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog pulses and the hang limit
  always @(posedge clk) begin
    if (wdog === 1'b1) begin
      wd_seen++;
    end
    cyc++;
    if (cyc == 30000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    #1;
    `CHK("out_c_rst", 1'b0, out_c)
    `CHK("out_d_rst", 1'b0, out_d)
    chk_rd(A_C_OUT, 4'h0, "c_out_rst");
    chk_rd(A_C_MODE, 4'h0, "c_mode_wo");
    chk_rd(6'h3f, 4'h0, "unmapped");
    wr(A_C_HIGH, 4'ha);
    chk_cnt(A_C_HIGH, 8'ha0, "c_low_rst");
    wr(A_C_LOW, 4'h3);
    chk_cnt(A_C_HIGH, 8'ha0, "c_low_only");
    wr(A_C_HIGH, 4'h5);
    chk_cnt(A_C_HIGH, 8'h53, "c_high_only");
    load(A_C_LOW, 8'h2f);
    rd(A_C_HIGH, v[7:4]);
    ticks(1);
    rd(A_C_LOW, v[3:0]);
    `CHK("c_latched", 8'h2f, v)
    tend("load_read");
    // random loads near and away from the wrap point, each counted on a random tap
    for (int i = 0; i < 8; i++) begin
      rl = i[0];
      l = i[1] ? 8'($random(seed)) : 8'hfb + 8'(i);
      n = 1 + ($random(seed) & 3);
      tp = ($random(seed) & 32'hff) % TAP_N;
      set_mode(A_C_MODE, {rl, 3'(tp)});
      load(A_C_LOW, l);
      ticks(n);
      chk_cnt(A_C_HIGH, exp_cnt(l, n, rl), "c_count");
    end
    tp = 0;
    tend("count");
    set_mode(A_C_MODE, 4'h8);
    load(A_C_LOW, 8'hfe);
    wr(A_C_OUT, 4'h1);
    ticks(0);
    `CHK("c_pin_sel", 1'b1, sel_c)
    chk_rd(A_C_OUT, 4'h1, "c_out_rb");
    for (int i = 0; i < 4; i++) begin
      wr(A_C_OUT, om[i]);
      ticks(2);
      `CHK("c_out", ex[i], out_c)
    end
    `CHK("c_irq", 1'b1, irq_c)
    wr(A_IRQ_C, 4'h0);
    ticks(0);
    `CHK("c_irq_clr", 1'b0, irq_c)
    `CHK("wd_off", 0, wd_seen)
    wr(A_WDOG, 4'h2);
    ticks(2);
    `CHK("wd_on", 1, wd_seen)
    wr(A_WDOG, 4'h0);
    wr(A_C_OUT, 4'h4);
    set_mode(A_C_MODE, 4'h0);
    load(A_C_LOW, 8'hfe);
    ticks(0);
    `CHK("c_pwm_lo", 1'b0, out_c)
    ticks(2);
    `CHK("c_pwm_hi", 1'b1, out_c)
    tend("first_out");
    set_mode(A_D_MODE, 4'h8);
    load(A_D_LOW, 8'hfe);
    wr(A_D_OUT, 4'h1);
    ticks(2);
    `CHK("d_out", 1'b1, out_d)
    `CHK("d_sel", 1'b1, sel_d)
    `CHK("d_irq", 1'b1, irq_d)
    chk_cnt(A_D_HIGH, 8'hfe, "d_reload");
    wr(A_IRQ_D, 4'h0);
    ticks(0);
    `CHK("d_irq_clr", 1'b0, irq_d)
    // force-low on the second pin while it stands high
    wr(A_D_OUT, 4'h2);
    ticks(2);
    `CHK("d_out_low", 1'b0, out_d)
    wr(A_IRQ_D, 4'h0);
    tend("second");
    // event counting for each edge code
    wr(A_D_OUT, 4'h0);
    wr(A_PINF, 4'h2);
    set_mode(A_D_MODE, {1'b0, SEL_EVENT});
    for (int i = 1; i < 4; i++) begin
      wr(A_EDGE, 4'(i));
      load(A_D_LOW, 8'h00);
      repeat (3) pulse();
      chk_cnt(A_D_HIGH, (i == 3) ? 8'h06 : 8'h03, "d_events");
    end
    tend("events");
    set_mode(A_D_MODE, 4'h0);
    wr(A_D_OUT, 4'h8);
    ticks(0);
    `CHK("d_sel_capt", 1'b0, sel_d)
    wr(A_EDGE, {2'h0, ED_RISE});
    ticks(5);
    pulse();
    rd(A_D_LOW, v[3:0]);
    rd(A_D_HIGH, v[7:4]);
    `CHK("d_capture", 8'h05, v)
    chk_rd(A_CAPT, 4'h1, "capt_status");
    `CHK("d_irq_capt", 1'b1, irq_d)
    pulse();
    chk_rd(A_CAPT, 4'h3, "capt_error");
    wr(A_CAPT, 4'h0);
    chk_rd(A_CAPT, 4'h0, "capt_clear");
    ticks(3);
    pulse();
    chk_cnt(A_D_HIGH, 8'h03, "d_recount");
    tend("capture");
    test_done();
  end
endmodule
